// file: iss_sensor.sv
`timescale 1ns/1ps
module iss_sensor
    import iss_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYCLES,
    parameter int FLASH_CYC  = FLASH_CYCLES
) (
    input  wire logic      clock,
    input  wire logic      rst_b,
    input  wire logic      clk_en,
    iss_link_if.sensor     link,
    input  wire logic [15:0] sample_value,
    output logic           flash_busy,
    output logic [15:0]    flash_count
);
    logic [1:0]  sclk_s_q, cs_s_q, mosi_s_q;
    logic        sclk_d1_q, cs_d1_q;
    logic [15:0] rx_q, tx_q;
    logic [4:0]  bitcnt_q;
    logic [7:0]  mem_q [NUM_REGS*2];
    logic [6:0]  rd_addr_q;
    logic [31:0] smp_cnt_q;
    logic [31:0] fl_cnt_q;
    logic [15:0] fcount_q;
    logic        drdy_q, miso_q, load_q;
    logic [15:0] sample_q;
    logic        rise, fall, frame_end;
    logic [6:0]  rx_addr;

    // pins pass two flops before use
    // idle levels at reset, so no false edge
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sclk_s_q  <= 2'b11;
            cs_s_q    <= 2'b11;
            mosi_s_q  <= 2'b00;
            sclk_d1_q <= 1'b1;
            cs_d1_q   <= 1'b1;
        end else if (clk_en) begin
            sclk_s_q  <= {sclk_s_q[0], link.sclk};
            cs_s_q    <= {cs_s_q[0], link.cs_b};
            mosi_s_q  <= {mosi_s_q[0], link.mosi};
            sclk_d1_q <= sclk_s_q[1];
            cs_d1_q   <= cs_s_q[1];
        end
    end

    // edges seen three clocks late, link must be slow
    // idle-high clock edges
    assign rise      = sclk_s_q[1] & ~sclk_d1_q & ~cs_s_q[1];
    assign fall      = ~sclk_s_q[1] & sclk_d1_q & ~cs_s_q[1];
    // a frame without sixteen rises is dropped
    // act on chip select rising
    assign frame_end = cs_s_q[1] & ~cs_d1_q;
    assign rx_addr   = rx_q[ADDR_MSB:ADDR_LSB];

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rx_q     <= '0;
            bitcnt_q <= '0;
        end else if (clk_en) begin
            if (cs_s_q[1]) begin
                bitcnt_q <= '0;
            end else if (rise) begin
                rx_q     <= {rx_q[14:0], mosi_s_q[1]};
                bitcnt_q <= bitcnt_q + 5'd1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tx_q   <= '0;
            miso_q <= 1'b0;
        end else if (clk_en) begin
            // reload while deselected, after the last frame
            if (cs_s_q[1] && cs_d1_q) begin
                // register = lower byte + 1 upper
                tx_q <= {mem_q[{rd_addr_q[6:1], 1'b1}],
                         mem_q[{rd_addr_q[6:1], 1'b0}]};
            end else if (fall) begin
                // first bit waits for the first fall
                miso_q <= tx_q[15];
                tx_q   <= {tx_q[14:0], 1'b0};
            end
        end
    end

    // only a full frame may move the reply address
    // latch read address per frame
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_addr_q <= '0;
        end else if (clk_en && frame_end && bitcnt_q == 5'(FRAME_BITS)) begin
            // after write, output left as address
            rd_addr_q <= rx_addr;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            smp_cnt_q <= '0;
            load_q    <= 1'b0;
            drdy_q    <= 1'b0;
            sample_q  <= '0;
        end else if (clk_en) begin
            load_q <= 1'b0;
            // pulse trails the load by one clock
            drdy_q <= load_q;
            if (smp_cnt_q == 32'(SAMPLE_CYC - 1)) begin
                smp_cnt_q <= '0;
                load_q    <= 1'b1;
                sample_q  <= sample_value;
            end else begin
                smp_cnt_q <= smp_cnt_q + 32'd1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fl_cnt_q <= '0;
            fcount_q <= '0;
        end else if (clk_en) begin
            if (fl_cnt_q != 32'd0) begin
                fl_cnt_q <= fl_cnt_q - 32'd1;
                if (fl_cnt_q == 32'd1) begin
                    fcount_q <= fcount_q + 16'd1;
                end
            // a command during a backup is ignored
            end else if (frame_end && bitcnt_q == 5'(FRAME_BITS) &&
                         rx_q[WR_BIT] && rx_addr == ADDR_GLOBAL_COMMAND_REG &&
                         rx_q[GLOB_FLASH_BIT]) begin
                fl_cnt_q <= 32'(FLASH_CYC);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS*2; i++) begin
                mem_q[i] <= '0;
            end
            mem_q[ADDR_SAMPLE_PERIOD_SETTING]     <= SAMPLE_PERIOD_SETTING_RESET[7:0];
            mem_q[ADDR_SAMPLE_PERIOD_SETTING + 1] <= SAMPLE_PERIOD_SETTING_RESET[15:8];
            mem_q[ADDR_MSC_CTRL]     <= MSC_CTRL_RESET[7:0];
            mem_q[ADDR_MSC_CTRL + 1] <= MSC_CTRL_RESET[15:8];
            mem_q[ADDR_SENS_AVG]     <= SENS_AVG_RESET[7:0];
            mem_q[ADDR_SENS_AVG + 1] <= SENS_AVG_RESET[15:8];
        end else if (clk_en) begin
            // flash count mirrored into its byte pair
            mem_q[ADDR_FLASH_WRITE_COUNTER]     <= fcount_q[7:0];
            mem_q[ADDR_FLASH_WRITE_COUNTER + 1] <= fcount_q[15:8];
            if (load_q) begin
                for (int i = ADDR_OUT_FIRST; i <= ADDR_OUT_LAST; i += 2) begin
                    mem_q[i]     <= sample_q[7:0];
                    mem_q[i + 1] <= sample_q[15:8];
                end
            end
            // read-only places keep their value
            // write byte at frame end
            if (frame_end && bitcnt_q == 5'(FRAME_BITS) && rx_q[WR_BIT] &&
                rx_addr != ADDR_FLASH_WRITE_COUNTER && rx_addr != ADDR_FLASH_WRITE_COUNTER + 1 &&
                (rx_addr < ADDR_OUT_FIRST || rx_addr > ADDR_OUT_LAST)) begin
                mem_q[rx_addr] <= rx_q[7:0];
            end
        end
    end


    // pins come straight from flops
    assign link.miso           = miso_q;
    assign link.data_ready_pin = drdy_q;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flash_busy  <= 1'b0;
            flash_count <= '0;
        end else if (clk_en) begin
            flash_busy  <= (fl_cnt_q != 32'd0);
            flash_count <= fcount_q;
        end
    end
endmodule

// file: iss_pkg.sv
package iss_pkg;
    localparam int          FRAME_BITS       = 16;
    localparam int          ADDR_BITS        = 7;
    localparam int          BYTE_BITS        = 8;
    localparam int          NUM_REGS         = 64;
    localparam int          WR_BIT           = 15;
    localparam int          ADDR_MSB         = 14;
    localparam int          ADDR_LSB         = 8;
    localparam int          CLK_HZ           = 20000000;
    localparam int          CLK_PERIOD_NS    = 50;
    // sample rate in milli-samples per second
    localparam longint      SAMPLE_RATE_MSPS = 819200;
    localparam int          SAMPLE_CYCLES    =
        int'((longint'(CLK_HZ) * 1000) / SAMPLE_RATE_MSPS);
    localparam int          FLASH_TIME_MS    = 50;
    localparam int          FLASH_CYCLES     = FLASH_TIME_MS * (CLK_HZ / 1000);
    localparam int          DRDY_CYCLES      = 1;
    localparam logic [6:0]  ADDR_FLASH_WRITE_COUNTER   = 7'h00;
    localparam logic [6:0]  ADDR_OUT_FIRST   = 7'h02;
    localparam logic [6:0]  ADDR_OUT_LAST    = 7'h17;
    localparam logic [6:0]  ADDR_GLOBAL_COMMAND_REG    = 7'h3e;
    localparam int          GLOB_FLASH_BIT   = 3;
    localparam logic [15:0] SAMPLE_PERIOD_SETTING_RESET   = 16'h0001;
    localparam logic [6:0]  ADDR_SAMPLE_PERIOD_SETTING    = 7'h36;
    localparam logic [15:0] MSC_CTRL_RESET   = 16'h0006;
    localparam logic [6:0]  ADDR_MSC_CTRL    = 7'h34;
    localparam logic [15:0] SENS_AVG_RESET   = 16'h0402;
    localparam logic [6:0]  ADDR_SENS_AVG    = 7'h38;
    // host register map
    localparam logic [31:0] HREG_CMD         = 32'h0000_0000;
    localparam logic [31:0] HREG_RDATA       = 32'h0000_0004;
    localparam logic [31:0] HREG_STATUS      = 32'h0000_0008;
    localparam logic [31:0] HREG_MASK        = 32'h0000_000c;
    localparam logic [31:0] HREG_CLKDIV      = 32'h0000_0010;
    localparam int          ST_DONE          = 0;
    localparam int          ST_DRDY          = 1;
    localparam int          ST_BUSY          = 2;
    localparam logic [7:0]  CLKDIV_RESET     = 8'h04;
endpackage

// file: iss_link_if.sv
`timescale 1ns/1ps
interface iss_link_if;
    logic sclk;
    logic cs_b;
    logic mosi;
    logic miso;
    logic data_ready_pin;
    modport sensor (
        input  sclk,
        input  cs_b,
        input  mosi,
        output miso,
        output data_ready_pin
    );
    modport master (
        output sclk,
        output cs_b,
        output mosi,
        input  miso,
        input  data_ready_pin
    );
endinterface

// file: iss_master.sv
`timescale 1ns/1ps
module iss_master
    import iss_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    iss_link_if.master       link,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hsel,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);
    typedef enum logic [1:0] {IDLE, SETUP, SHIFT, GAP} iss_st_type;
    iss_st_type  st_q;
    logic        ph_q, ph_wr_q;
    logic [31:0] ph_addr_q;
    logic [15:0] txd_q, rxd_q, rdata_q;
    logic [2:0]  status_q, mask_q;
    logic [7:0]  div_q, divcnt_q;
    logic [4:0]  bits_q;
    logic        sclk_q, cs_q, mosi_q;
    logic [1:0]  miso_s_q, drdy_s_q;
    logic        drdy_d1_q, start, done_ev, drdy_ev;

    assign start   = ph_q && ph_wr_q && ph_addr_q == HREG_CMD && st_q == IDLE;
    assign drdy_ev = drdy_s_q[1] & ~drdy_d1_q;
    assign done_ev = (st_q == GAP) && divcnt_q == 8'd0;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ph_q      <= 1'b0;
            ph_wr_q   <= 1'b0;
            ph_addr_q <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (clk_en) begin
            ph_q <= hsel && hready && htrans[1];
            if (hsel && hready && htrans[1]) begin
                ph_wr_q   <= hwrite;
                ph_addr_q <= haddr;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hrdata <= '0;
        end else if (clk_en) begin
            case (haddr[4:0])
                HREG_RDATA[4:0]:  hrdata <= {16'h0000, rdata_q};
                HREG_STATUS[4:0]: hrdata <= {29'h0, status_q};
                HREG_MASK[4:0]:   hrdata <= {29'h0, mask_q};
                HREG_CLKDIV[4:0]: hrdata <= {24'h0, div_q};
                default:          hrdata <= '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mask_q <= '0;
            div_q  <= CLKDIV_RESET;
        end else if (clk_en && ph_q && ph_wr_q) begin
            if (ph_addr_q == HREG_MASK) mask_q <= hwdata[2:0];
            // below two the synced reply bit comes too late
            if (ph_addr_q == HREG_CLKDIV && hwdata[7:0] > 8'd1)
                div_q <= hwdata[7:0];
        end
    end

    // sticky events, set beats write-one clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            status_q <= '0;
            irq      <= 1'b0;
        end else if (clk_en) begin
            status_q[ST_DONE] <= done_ev | (status_q[ST_DONE] &
                ~(ph_q && ph_wr_q && ph_addr_q == HREG_STATUS &&
                  hwdata[ST_DONE]));
            status_q[ST_DRDY] <= drdy_ev | (status_q[ST_DRDY] &
                ~(ph_q && ph_wr_q && ph_addr_q == HREG_STATUS &&
                  hwdata[ST_DRDY]));
            status_q[ST_BUSY] <= (st_q != IDLE);
            irq <= |(status_q[1:0] & mask_q[1:0]);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            miso_s_q  <= '0;
            drdy_s_q  <= '0;
            drdy_d1_q <= 1'b0;
        end else if (clk_en) begin
            miso_s_q  <= {miso_s_q[0], link.miso};
            drdy_s_q  <= {drdy_s_q[0], link.data_ready_pin};
            drdy_d1_q <= drdy_s_q[1];
        end
    end

    // clock idles high, cs low per frame
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            st_q     <= IDLE;
            sclk_q   <= 1'b1;
            cs_q     <= 1'b1;
            mosi_q   <= 1'b0;
            divcnt_q <= '0;
            bits_q   <= '0;
            txd_q    <= '0;
            rxd_q    <= '0;
            rdata_q  <= '0;
        end else if (clk_en) begin
            if (divcnt_q != 8'd0) divcnt_q <= divcnt_q - 8'd1;
            case (st_q)
                IDLE: if (start) begin
                    txd_q    <= hwdata[15:0];
                    cs_q     <= 1'b0;
                    divcnt_q <= div_q;
                    bits_q   <= 5'(FRAME_BITS);
                    st_q     <= SETUP;
                end
                SETUP: if (divcnt_q == 8'd0) begin
                    sclk_q   <= 1'b0;
                    mosi_q   <= txd_q[15];
                    txd_q    <= {txd_q[14:0], 1'b0};
                    divcnt_q <= div_q;
                    st_q     <= SHIFT;
                end
                SHIFT: if (divcnt_q == 8'd0) begin
                    divcnt_q <= div_q;
                    if (!sclk_q) begin
                        sclk_q <= 1'b1;
                        bits_q <= bits_q - 5'd1;
                    end else begin
                        // reply bit taken at end of high phase
                        // synced reply lags the fall by five clocks
                        rxd_q <= {rxd_q[14:0], miso_s_q[1]};
                        if (bits_q == 5'd0) begin
                            cs_q    <= 1'b1;
                            st_q    <= GAP;
                            rdata_q <= {rxd_q[14:0], miso_s_q[1]};
                        end else begin
                            sclk_q <= 1'b0;
                            mosi_q <= txd_q[15];
                            txd_q  <= {txd_q[14:0], 1'b0};
                        end
                    end
                end
                GAP: if (divcnt_q == 8'd0) st_q <= IDLE;
                default: st_q <= IDLE;
            endcase
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_b = cs_q;
    assign link.mosi = mosi_q;
endmodule

// file: iss_link_sva.sv
`timescale 1ns/1ps
module iss_link_sva
    import iss_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic mosi,
    input wire logic miso,
    input wire logic data_ready_pin
);
    logic [4:0]  rises_q;
    logic        sclk_q;
    logic [15:0] gap_q;
    logic        seen_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    // rising edges inside one frame
    always_ff @(posedge clock) begin
        sclk_q <= sclk;
        if (!rst_b || cs_b) begin
            rises_q <= 5'h00;
        end else if (sclk && !sclk_q) begin
            rises_q <= rises_q + 5'h01;
        end
    end

    // idle cycles between data-ready pulses
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            gap_q  <= 16'h0000;
            seen_q <= 1'b0;
        end else if (data_ready_pin) begin
            gap_q  <= 16'h0000;
            seen_q <= 1'b1;
        end else begin
            gap_q  <= gap_q + 16'h0001;
        end
    end

    chk_idle_clock_high:
        assert property (cs_b && $past(cs_b) |-> sclk)
        else $error("sclk low while deselected");
    chk_select_clock_high:
        assert property ($fell(cs_b) |-> sclk)
        else $error("select fell with sclk low");
    chk_high_phase_len:
        assert property ($rose(sclk) |-> sclk [*3])
        else $error("sclk high phase too short");
    chk_low_phase_len:
        assert property ($fell(sclk) |-> !sclk [*3])
        else $error("sclk low phase too short");
    chk_frame_sixteen_rises:
        assert property ($rose(cs_b) |-> rises_q == 5'h10)
        else $error("frame without sixteen clock rises");
    chk_miso_on_fall:
        assert property (!cs_b && !$past(cs_b, 3) && $changed(miso) |-> !sclk)
        else $error("miso moved outside low clock phase");
    chk_mosi_steady_rise:
        assert property ($rose(sclk) && !cs_b |-> $stable(mosi))
        else $error("mosi moved at sampling edge");
    chk_ready_one_cycle:
        assert property ($rose(data_ready_pin) |=> !data_ready_pin)
        else $error("data ready wider than one cycle");
    chk_sample_period_exact:
        assert property (data_ready_pin && seen_q |->
                         gap_q == 16'(SAMPLE_CYC - 1))
        else $error("sample period off");
endmodule

// file: test_inertial_sensor_spi_slave.sv
`timescale 1ns/1ps
module test_inertial_sensor_spi_slave
    import iss_pkg::*;
();
    localparam int SCYC = 24;
    // short backup so the run stays brief
    localparam int FCYC = 200;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic        hwrite, hreadyout, hresp, irq, flash_busy;
    logic        hsel = 1'b1;
    logic [15:0] sample_value, flash_count, rx;
    logic [15:0] mdl [64];
    logic [31:0] rnd_q = 32'h10;
    logic [31:0] r;
    logic [6:0]  tbl [5];
    logic [6:0]  a;
    int          err_count = 0;
    int          samples_checked = 0;
    int          n;

    always #25 clock = ~clock;

    iss_link_if iss_link_if_i ();
    iss_sensor #(.SAMPLE_CYC(SCYC), .FLASH_CYC(FCYC)) iss_sensor_i (
        .clock(clock), .rst_b(rst_b), .clk_en(1'b1), .link(iss_link_if_i),
        .sample_value(sample_value), .flash_busy(flash_busy),
        .flash_count(flash_count));
    iss_master iss_master_i (
        .clock(clock), .rst_b(rst_b), .clk_en(1'b1), .link(iss_link_if_i),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hsel(hsel), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    iss_link_sva #(.SAMPLE_CYC(SCYC)) iss_link_sva_i (
        .clock(clock), .rst_b(rst_b), .sclk(iss_link_if_i.sclk),
        .cs_b(iss_link_if_i.cs_b), .mosi(iss_link_if_i.mosi),
        .miso(iss_link_if_i.miso),
        .data_ready_pin(iss_link_if_i.data_ready_pin));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction

    function automatic logic [15:0] rq(input logic [6:0] ad);
        return {1'b0, ad, 8'h00};
    endfunction

    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic await_ready;
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            err_count++;
            report_and_stop();
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] ad,
                       input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'b10;
        haddr  <= ad;
        hwrite <= w;
        await_ready();
        htrans <= 2'b00;
        hwdata <= d;
        await_ready();
        q = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ad, d, q);
    endtask

    // one 16-bit frame through the controller, reply returned
    task automatic frame(input logic [15:0] f, output logic [15:0] q);
        logic [31:0] s;
        int k;
        wr(HREG_CMD, {16'h0000, f});
        k = 0;
        do begin
            bus(1'b0, HREG_STATUS, 32'h0, s);
            k++;
        end while ((s[ST_DONE] !== 1'b1 || s[ST_BUSY] !== 1'b0) && k < 400);
        if (s[ST_DONE] !== 1'b1 || s[ST_BUSY] !== 1'b0) begin
            err_count++;
            report_and_stop();
        end
        wr(HREG_STATUS, 32'h1 << ST_DONE);
        bus(1'b0, HREG_RDATA, 32'h0, s);
        q = s[15:0];
    endtask

    // read-only places ignore the byte
    task automatic wbyte(input logic [6:0] ad, input logic [7:0] b);
        logic [15:0] q;
        frame({1'b1, ad, b}, q);
        if (ad > ADDR_OUT_LAST && ad[0])
            mdl[ad[6:1]][15:8] = b;
        else if (ad > ADDR_OUT_LAST)
            mdl[ad[6:1]][7:0] = b;
    endtask

    // request frame then a dummy frame carrying the reply
    task automatic rreg(input logic [6:0] ad);
        logic [15:0] q;
        frame(rq(ad), q);
        frame(rq(7'h00), q);
        check({16'h0, q}, {16'h0, mdl[ad[6:1]]});
    endtask

    initial begin
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        sample_value = 16'h0000;
        for (int i = 0; i < 64; i++) mdl[i] = 16'h0000;
        mdl[ADDR_SAMPLE_PERIOD_SETTING[6:1]] = SAMPLE_PERIOD_SETTING_RESET;
        mdl[ADDR_MSC_CTRL[6:1]] = MSC_CTRL_RESET;
        mdl[ADDR_SENS_AVG[6:1]] = SENS_AVG_RESET;
        tbl = '{ADDR_SAMPLE_PERIOD_SETTING, 7'h35, ADDR_SENS_AVG, 7'h37, ADDR_FLASH_WRITE_COUNTER};
        tick(5);
        rst_b <= 1'b1;
        tick(2);
        check({31'h0, iss_link_if_i.sclk}, 32'h1);
        check({31'h0, iss_link_if_i.cs_b}, 32'h1);
        bus(1'b0, HREG_CLKDIV, 32'h0, r);
        check(r, {24'h0, CLKDIV_RESET});
        bus(1'b0, 32'h0000_0020, 32'h0, r);
        check(r, 32'h0);
        bus(1'b0, HREG_MASK, 32'h0, r);
        check(r, 32'h0);
        // pipelined reads, reply of each request in the next frame
        frame(rq(tbl[0]), rx);
        for (int i = 1; i < 5; i++) begin
            frame(rq(tbl[i]), rx);
            check({16'h0, rx}, {16'h0, mdl[tbl[i-1][6:1]]});
        end
        frame(rq(7'h00), rx);
        check({16'h0, rx}, {16'h0, mdl[0]});
        // faster link clock; zero and one are refused
        wr(HREG_CLKDIV, 32'h0);
        wr(HREG_CLKDIV, 32'h3);
        wr(HREG_CLKDIV, 32'h1);
        bus(1'b0, HREG_CLKDIV, 32'h0, r);
        check(r, 32'h3);
        // byte writes; first two hit read-only places
        for (int k = 0; k < 10; k++) begin
            rnd_q = xs(rnd_q);
            a = (k == 0) ? 7'h0b : (k == 1) ? 7'h01 : 7'h1a + 7'(rnd_q % 26);
            wbyte(a, rnd_q[15:8]);
            rreg(a);
        end
        tbl = '{7'h0a, ADDR_OUT_LAST, ADDR_OUT_FIRST, 7'h0f, 7'h10};
        for (int k = 0; k < 3; k++) begin
            rnd_q = xs(rnd_q);
            sample_value <= rnd_q[15:0];
            for (int j = 1; j < 12; j++) mdl[j] = rnd_q[15:0];
            tick(2 * SCYC);
            rreg(tbl[k]);
        end
        for (int k = 1; k < 3; k++) begin
            wbyte(ADDR_GLOBAL_COMMAND_REG, 8'(1 << GLOB_FLASH_BIT));
            check({31'h0, flash_busy}, 32'h1);
            n = 0;
            while (flash_busy !== 1'b0 && n < FCYC + 50) begin
                tick(1);
                n++;
            end
            check({31'h0, flash_busy}, 32'h0);
            mdl[0] = 16'(k);
            check({16'h0, flash_count}, 32'(k));
            rreg(ADDR_FLASH_WRITE_COUNTER);
        end
        // sticky data-ready flag, masked level interrupt
        wr(HREG_MASK, 32'h1 << ST_DRDY);
        tick(3);
        check({31'h0, irq}, 32'h1);
        n = 0;
        while (iss_link_if_i.data_ready_pin !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        tick(4);
        wr(HREG_STATUS, 32'h1 << ST_DRDY);
        tick(2);
        check({31'h0, irq}, 32'h0);
        bus(1'b0, HREG_STATUS, 32'h0, r);
        check({31'h0, r[ST_DRDY]}, 32'h0);
        tick(SCYC + 5);
        check({31'h0, irq}, 32'h1);
        wr(HREG_MASK, 32'h0);
        tick(3);
        check({31'h0, irq}, 32'h0);
        report_and_stop();
    end
endmodule
